// ===== src/ssp_defs.svh
// Purpose: Constants of the synchronous serial port
// Assumes: 125 MHz system clock
// Notes: Widths, depth, reset values, bit and edge counts and timing limits
`ifndef SSP_DEFS_SVH
`define SSP_DEFS_SVH

// ----------------------------------------
// Data and counts
// ----------------------------------------
`define SSP_BITS 8
`define SSP_BIT_LAST 4'h7
`define SSP_EDGE_LAST 5'h0f
`define SSP_FIFO_DEPTH 8
`define SSP_BYTE_RST 8'h00

// ----------------------------------------
// Timing
// ----------------------------------------
`define SSP_CLK_MHZ 125
`define SSP_MAX_RATE_MBPS 4
`define SSP_MIN_HALF ((`SSP_CLK_MHZ + 2 * `SSP_MAX_RATE_MBPS - 1) / (2 * `SSP_MAX_RATE_MBPS))

`endif

// ===== src/ssp_pkg.sv
// Purpose: Types of the synchronous serial port
// Assumes: Nothing
// Notes: Constants live in ssp_defs.svh
`default_nettype none
package ssp_pkg;

  // ----------------------------------------
  // Master shift clock sequencer
  // ----------------------------------------
  typedef enum logic {
    MS_IDLE,
    MS_RUN
  } ssp_mstate_t;

endpackage

`default_nettype wire

// ===== src/ssp_port.sv
// Purpose: Full-duplex byte serial port, master or slave, with transmit FIFO
// Assumes: All inputs synchronous to clk_sys; shift clock input oversampled
// Notes: Writes enter an 8-word FIFO that loads the shifter when it is free
`timescale 1ns/1ps
`default_nettype none
`include "ssp_defs.svh"

// ----------------------------------------
// Transmit FIFO
// ----------------------------------------
module ssp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0] cnt_q;
  logic [AW:0] cnt_d;
  logic nfull_q;
  logic empty_q;
  wire push = in_valid & nfull_q;
  wire pop = out_ready & ~empty_q;

  assign cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
  assign in_ready = nfull_q;
  assign out_valid = ~empty_q;
  assign out_data = mem[rp_q];

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wp_q] <= in_data;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
      nfull_q <= 1'b1;
      empty_q <= 1'b1;
    end else begin
      wp_q <= push ? AW'((wp_q + 1'b1) % DEPTH) : wp_q;
      rp_q <= pop ? AW'((rp_q + 1'b1) % DEPTH) : rp_q;
      cnt_q <= cnt_d;
      nfull_q <= (cnt_d != (AW+1)'(DEPTH));
      empty_q <= (cnt_d == '0);
    end
  end
endmodule

// ----------------------------------------
// Serial port
// ----------------------------------------
module ssp_port (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Control
  input wire logic port_enable,
  input wire logic master_select,
  input wire logic clock_mode_select,
  input wire logic clock_idle_level,
  input wire logic [7:0] clock_divider,
  input wire logic echo_enable,
  input wire logic ready_set,
  input wire logic rx_irq_enable,
  input wire logic tx_irq_enable,
  input wire logic overrun_irq_enable,
  // Transmit stream
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [7:0] wr_data,
  // Receive read
  input wire logic rd_strobe,
  output logic [7:0] rd_data,
  // Status
  output logic rx_buffer_full,
  output logic shifter_busy,
  output logic overrun_flag,
  output logic irq,
  // Shift clock pin
  input wire logic shift_clock_in,
  output logic shift_clock_out,
  output logic shift_clock_oe,
  // Data pins
  input wire logic data_pin_a_in,
  output logic data_pin_a_out,
  output logic data_pin_a_oe,
  input wire logic data_pin_b_in,
  output logic data_pin_b_out,
  output logic data_pin_b_oe,
  // Slave select and ready
  input wire logic slave_select_n,
  output logic slave_ready_n_out,
  output logic slave_ready_n_oe
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  ssp_pkg::ssp_mstate_t mst_q;
  logic [7:0] shreg_q;
  logic [7:0] rbuf_q;
  logic [3:0] bitcnt_q;
  logic [4:0] edge_cnt_q;
  logic [7:0] half_cnt_q;
  logic sck_q;
  logic dout_q;
  logic busy_q;
  logic rbf_q;
  logic pend_q;
  logic ovr_q;
  logic txv_q;
  logic echo_q;
  logic rdy_q;
  logic sck_in_q;
  logic ss_n_q;
  logic [7:0] rd_data_q;
  logic a_out_q;
  logic a_oe_q;
  logic b_out_q;
  logic b_oe_q;
  logic sck_out_q;
  logic sck_oe_q;
  logic rdy_out_q;
  logic rdy_oe_q;
  logic irq_q;
  logic fifo_valid;
  logic [7:0] fifo_data;

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  wire is_master = master_select;
  wire slv_sel = port_enable & ~is_master & ~slave_select_n;
  wire ss_fall = slv_sel & ss_n_q;
  wire sample_lead = (clock_mode_select == clock_idle_level);
  wire [7:0] half_len = (clock_divider < 8'(`SSP_MIN_HALF)) ? 8'(`SSP_MIN_HALF) : clock_divider;
  wire half_tick = (mst_q == ssp_pkg::MS_RUN) && (half_cnt_q == 8'h00);
  wire m_lead = half_tick & ~edge_cnt_q[0];
  wire m_trail = half_tick & edge_cnt_q[0];
  wire s_rise = slv_sel & shift_clock_in & ~sck_in_q;
  wire s_fall = slv_sel & ~shift_clock_in & sck_in_q;
  wire s_lead = clock_idle_level ? s_fall : s_rise;
  wire s_trail = clock_idle_level ? s_rise : s_fall;
  wire lead_ev = is_master ? m_lead : s_lead;
  wire trail_ev = is_master ? m_trail : s_trail;
  wire sample_ev = sample_lead ? lead_ev : trail_ev;
  wire out_ev = (sample_lead ? trail_ev : lead_ev) & (bitcnt_q != 4'h0);
  wire din = is_master ? data_pin_b_in : data_pin_a_in;
  wire [7:0] shreg_in = {shreg_q[6:0], din};
  wire done = sample_ev & (bitcnt_q == `SSP_BIT_LAST);
  wire pop = fifo_valid & port_enable & ~busy_q & (bitcnt_q == 4'h0)
    & (mst_q == ssp_pkg::MS_IDLE);
  wire rx_take = done & (~rbf_q | rd_strobe);
  wire pend_take = rd_strobe & pend_q & ~done;
  wire ovr_set = is_master & pop & rbf_q & pend_q & ~rd_strobe;

  // ----------------------------------------
  // Transmit FIFO
  // ----------------------------------------
  ssp_fifo #(
    .WIDTH(`SSP_BITS),
    .DEPTH(`SSP_FIFO_DEPTH)
  ) u_fifo (
    .clk_sys(clk_sys),
    .rst(rst),
    .in_valid(wr_valid),
    .in_ready(wr_ready),
    .in_data(wr_data),
    .out_valid(fifo_valid),
    .out_ready(pop),
    .out_data(fifo_data)
  );

  // ----------------------------------------
  // Master clock sequencer
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst || !port_enable || !is_master) begin
      mst_q <= ssp_pkg::MS_IDLE;
      half_cnt_q <= 8'h00;
      edge_cnt_q <= 5'h00;
      sck_q <= clock_idle_level;
    end else if (pop) begin
      mst_q <= ssp_pkg::MS_RUN;
      half_cnt_q <= half_len - 8'h01;
      edge_cnt_q <= 5'h00;
      sck_q <= clock_idle_level;
    end else if (half_tick) begin
      sck_q <= ~sck_q;
      half_cnt_q <= half_len - 8'h01;
      edge_cnt_q <= edge_cnt_q + 5'h01;
      if (edge_cnt_q == `SSP_EDGE_LAST) begin
        mst_q <= ssp_pkg::MS_IDLE;
      end
    end else if (mst_q == ssp_pkg::MS_RUN) begin
      half_cnt_q <= half_cnt_q - 8'h01;
    end else begin
      sck_q <= clock_idle_level;
    end
  end

  // ----------------------------------------
  // Shifter
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      shreg_q <= `SSP_BYTE_RST;
      bitcnt_q <= 4'h0;
      dout_q <= 1'b0;
      echo_q <= 1'b0;
      sck_in_q <= 1'b0;
      ss_n_q <= 1'b1;
    end else begin
      sck_in_q <= shift_clock_in;
      ss_n_q <= slave_select_n;
      if (!port_enable || (!is_master && slave_select_n)) begin
        bitcnt_q <= 4'h0;
        echo_q <= 1'b0;
      end else if (sample_ev) begin
        shreg_q <= shreg_in;
        bitcnt_q <= done ? 4'h0 : bitcnt_q + 4'h1;
        if (bitcnt_q == 4'h0) begin
          echo_q <= ~is_master & ~txv_q & echo_enable;
        end
      end
      if (pop) begin
        shreg_q <= fifo_data;
        dout_q <= fifo_data[7];
      end else if (ss_fall) begin
        dout_q <= shreg_q[7];
      end else if (out_ev) begin
        dout_q <= echo_q ? shreg_q[0] : shreg_q[7];
      end
    end
  end

  // ----------------------------------------
  // Flags and read buffer
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst || !port_enable) begin
      busy_q <= 1'b0;
      rbf_q <= 1'b0;
      pend_q <= 1'b0;
      ovr_q <= 1'b0;
      txv_q <= 1'b0;
    end else begin
      if (done) begin
        busy_q <= 1'b0;
        txv_q <= 1'b0;
      end else if (pop || (sample_ev && bitcnt_q == 4'h0)) begin
        busy_q <= 1'b1;
        txv_q <= txv_q | pop;
      end else if (!is_master && slave_select_n && bitcnt_q != 4'h0) begin
        busy_q <= 1'b0;
        txv_q <= 1'b0;
      end
      if (rx_take) begin
        rbuf_q <= shreg_in;
        rbf_q <= 1'b1;
      end else if (done) begin
        pend_q <= 1'b1;
      end else if (pend_take) begin
        rbuf_q <= shreg_q;
        pend_q <= 1'b0;
      end else if (rd_strobe && !pend_q) begin
        rbf_q <= 1'b0;
      end
      if (ovr_set) begin
        ovr_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rd_data_q <= `SSP_BYTE_RST;
    end else if (rd_strobe) begin
      rd_data_q <= rbuf_q;
    end
  end

  // ----------------------------------------
  // Slave ready and interrupt
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst || !port_enable) begin
      rdy_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      rdy_q <= ready_set | (rdy_q & ~done);
      irq_q <= (rbf_q & rx_irq_enable) | (~busy_q & tx_irq_enable)
        | (ovr_q & overrun_irq_enable & is_master);
    end
  end

  // ----------------------------------------
  // Pin registers
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      a_out_q <= 1'b0;
      a_oe_q <= 1'b0;
      b_out_q <= 1'b0;
      b_oe_q <= 1'b0;
      sck_out_q <= 1'b0;
      sck_oe_q <= 1'b0;
      rdy_out_q <= 1'b1;
      rdy_oe_q <= 1'b0;
    end else begin
      a_out_q <= dout_q;
      a_oe_q <= is_master;
      b_out_q <= dout_q;
      b_oe_q <= slv_sel;
      sck_out_q <= sck_q;
      sck_oe_q <= is_master;
      rdy_out_q <= ~rdy_q;
      rdy_oe_q <= slv_sel;
    end
  end

  assign rd_data = rd_data_q;
  assign rx_buffer_full = rbf_q;
  assign shifter_busy = busy_q;
  assign overrun_flag = ovr_q;
  assign irq = irq_q;
  assign shift_clock_out = sck_out_q;
  assign shift_clock_oe = sck_oe_q;
  assign data_pin_a_out = a_out_q;
  assign data_pin_a_oe = a_oe_q;
  assign data_pin_b_out = b_out_q;
  assign data_pin_b_oe = b_oe_q;
  assign slave_ready_n_out = rdy_out_q;
  assign slave_ready_n_oe = rdy_oe_q;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_burst_start: assert property (@(posedge clk_sys) disable iff (rst)
    pop && is_master |=> mst_q == ssp_pkg::MS_RUN)
    else $error("Master write did not start a burst");
  a_idle_clock: assert property (@(posedge clk_sys) disable iff (rst)
    mst_q == ssp_pkg::MS_IDLE && $stable(clock_idle_level) && !pop ##1
    mst_q == ssp_pkg::MS_IDLE && $stable(clock_idle_level) |-> sck_q == clock_idle_level)
    else $error("Shift clock not at idle level");
  a_disable_clear: assert property (@(posedge clk_sys) disable iff (rst)
    !port_enable |=> !busy_q && !rbf_q && !ovr_q)
    else $error("Disable left a flag set");
  a_overrun_set: assert property (@(posedge clk_sys) disable iff (rst)
    port_enable && is_master && pop && rbf_q && pend_q && !rd_strobe |=> ovr_q)
    else $error("Overrun not flagged");
  a_rbf_fill: assert property (@(posedge clk_sys) disable iff (rst)
    port_enable && done |=> rbf_q)
    else $error("Buffer full not set after transfer");
  a_rbf_clear: assert property (@(posedge clk_sys) disable iff (rst)
    port_enable && rd_strobe && !pend_q && !done |=> !rbf_q)
    else $error("Buffer full not cleared by read");
  a_ready_drop: assert property (@(posedge clk_sys) disable iff (rst)
    port_enable && done && !ready_set |=> !rdy_q ##1 rdy_out_q)
    else $error("Slave ready not released after byte");
  a_slave_release: assert property (@(posedge clk_sys) disable iff (rst)
    slave_select_n ##1 slave_select_n |-> !b_oe_q && !rdy_oe_q)
    else $error("Slave drives while deselected");
  a_resync_count: assert property (@(posedge clk_sys) disable iff (rst)
    port_enable && !is_master && slave_select_n |=> bitcnt_q == 4'h0)
    else $error("Bit count kept across deselect");
  a_irq_write: assert property (@(posedge clk_sys) disable iff (rst)
    port_enable && !busy_q && tx_irq_enable ##1 port_enable |-> irq_q)
    else $error("Write interrupt missing");
  a_busy_write: assert property (@(posedge clk_sys) disable iff (rst)
    port_enable && pop |=> busy_q && shreg_q == $past(fifo_data))
    else $error("Shifter not loaded by write");

endmodule

`default_nettype wire

// ===== sim/ssp_slave_model.sv
// Purpose: Behavioural slave on the far side of the port in master mode
// Assumes: Shift clock edges come clean from the master's register
// Notes: A released data line shows the inverse of its last value
`timescale 1ns/1ps
`default_nettype none
module ssp_slave_model (
  // Link
  input wire logic sck,
  input wire logic sel_n,
  input wire logic mosi,
  output logic miso,
  // Setup
  input wire logic sample_fall,
  input wire logic [7:0] tx_byte,
  output logic [7:0] rx_byte
);
  // ----------------------------------------
  // Shifter
  // ----------------------------------------
  logic [7:0] sh;
  logic sel_q;
  int nsamp;
  initial begin
    sh = 8'h00;
    sel_q = 1'b1;
    nsamp = 0;
    miso = 1'b0;
    rx_byte = 8'h00;
    forever begin
      @(sck or sel_n);
      if (sel_n !== sel_q) begin
        sel_q = sel_n;
        if (!sel_n) begin
          sh = tx_byte;
          nsamp = 0;
          miso = tx_byte[7];
        end else begin
          miso = ~miso;
        end
      end else if (!sel_n && (sck ^ sample_fall)) begin
        sh = {sh[6:0], mosi};
        nsamp++;
        if (nsamp % 8 == 0) begin
          rx_byte = sh;
        end
      end else if (!sel_n && nsamp > 0) begin
        miso = sh[7];
      end
    end
  end
endmodule
`default_nettype wire

// ===== sim/ssp_port_test.sv
// Purpose: Self-checking bench of the serial port
// Assumes: Slave model on the far side in master mode
// Notes: The bench plays the master itself in slave mode
`timescale 1ns/1ps
`default_nettype none
module ssp_port_test;
  // ----------------------------------------
  // Signals and instances
  // ----------------------------------------
  logic clk_sys = 1'b0, rst = 1'b1, port_enable = 1'b1, master_select = 1'b1;
  logic clock_mode_select = 1'b0, clock_idle_level = 1'b0, echo_enable = 1'b0;
  logic ready_set = 1'b0, rx_irq_enable = 1'b0, tx_irq_enable = 1'b0;
  logic overrun_irq_enable = 1'b0, wr_valid = 1'b0, rd_strobe = 1'b0;
  logic tb_sck = 1'b0, tb_a = 1'b0, slave_select_n = 1'b1, pt_sel_n = 1'b1;
  logic [7:0] clock_divider = 8'h10, wr_data = 8'h00, pt_tx = 8'h00, rd_data, pt_rx;
  logic wr_ready, shifter_busy, rx_buffer_full, overrun_flag, irq, pt_miso;
  logic shift_clock_out, shift_clock_oe, data_pin_a_out, data_pin_a_oe;
  logic data_pin_b_out, data_pin_b_oe, slave_ready_n_out, slave_ready_n_oe;
  wire logic sck_w, pa_w, pb_w;
  int err_count = 0, n_tests = 0, cycles = 0;
  always #4 clk_sys = ~clk_sys;
  assign sck_w = shift_clock_oe ? shift_clock_out : tb_sck;
  assign pa_w = data_pin_a_oe ? data_pin_a_out : tb_a;
  assign pb_w = data_pin_b_oe ? data_pin_b_out : pt_miso;
  ssp_port ssp_port_i (.clk_sys, .rst, .port_enable, .master_select, .clock_mode_select,
    .clock_idle_level, .clock_divider, .echo_enable, .ready_set, .rx_irq_enable,
    .tx_irq_enable, .overrun_irq_enable, .wr_valid, .wr_ready, .wr_data, .rd_strobe,
    .rd_data, .rx_buffer_full, .shifter_busy, .overrun_flag, .irq, .shift_clock_in(sck_w),
    .shift_clock_out, .shift_clock_oe, .data_pin_a_in(pa_w), .data_pin_a_out, .data_pin_a_oe,
    .data_pin_b_in(pb_w), .data_pin_b_out, .data_pin_b_oe, .slave_select_n,
    .slave_ready_n_out, .slave_ready_n_oe);
  ssp_slave_model ssp_slave_model_i (.sck(sck_w), .sel_n(pt_sel_n), .mosi(pa_w),
    .miso(pt_miso), .sample_fall(clock_mode_select), .tx_byte(pt_tx), .rx_byte(pt_rx));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic report_and_stop;
    $display("Checks %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input bit ok, input string msg);
    n_tests++;
    if (!ok) begin
      $display("BAD %0t %s", $time, msg);
      err_count++;
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic put(input logic [7:0] d);
    wr_valid = 1'b1;
    wr_data = d;
    tick(1);
    wr_valid = 1'b0;
  endtask
  task automatic rd(input logic [7:0] exp, input logic full);
    rd_strobe = 1'b1;
    tick(1);
    rd_strobe = 1'b0;
    tick(1);
    chk(rd_data === exp, "read data");
    chk(rx_buffer_full === full, "buffer flag after read");
  endtask
  task automatic m_xfer(input logic md, idl, input logic [7:0] tx, rx, input int hp,
    input logic rd_it);
    int n = 0, gap = 0, first = 0, cyc = 0;
    logic last;
    clock_mode_select = md;
    clock_idle_level = idl;
    clock_divider = hp[7:0];
    pt_tx = rx;
    tick(4);
    pt_sel_n = 1'b0;
    chk(shift_clock_out === idl, "idle level before");
    last = shift_clock_out;
    put(tx);
    while (cyc < 4000 && !(n >= 16 && gap > 4 && shifter_busy === 1'b0)) begin
      tick(1);
      cyc++;
      gap++;
      if (shift_clock_out !== last) begin
        if (n == 0) begin
          first = cyc;
        end else begin
          chk(gap == hp, "half period");
        end
        n++;
        gap = 0;
        last = shift_clock_out;
      end
    end
    if (md == idl) begin
      chk(first >= hp && first <= 3 * hp + 3, "start delay");
    end else begin
      chk(first <= 2 * hp + 3, "start delay");
    end
    chk(n == 16 && shift_clock_out === idl, "pulse count");
    chk(pt_rx === tx && rx_buffer_full === 1'b1, "master byte");
    pt_sel_n = 1'b1;
    tick(1);
    if (rd_it) begin
      rd(rx, 1'b0);
    end
  endtask
  task automatic t_overrun;
    m_xfer(1'b0, 1'b0, 8'h11, 8'h81, 16, 1'b0);
    m_xfer(1'b0, 1'b0, 8'h22, 8'h82, 16, 1'b0);
    rd(8'h81, 1'b1);
    m_xfer(1'b0, 1'b0, 8'h33, 8'h83, 16, 1'b0);
    chk(overrun_flag === 1'b0, "early overrun");
    rx_irq_enable = 1'b1;
    tick(3);
    chk(irq === 1'b1, "read irq");
    rx_irq_enable = 1'b0;
    overrun_irq_enable = 1'b1;
    m_xfer(1'b0, 1'b0, 8'h44, 8'h84, 16, 1'b0);
    chk(overrun_flag === 1'b1 && irq === 1'b1, "overrun");
    port_enable = 1'b0;
    tick(3);
    chk(overrun_flag === 1'b0 && rx_buffer_full === 1'b0 && irq === 1'b0, "disable");
    overrun_irq_enable = 1'b0;
    port_enable = 1'b1;
    tx_irq_enable = 1'b1;
    tick(3);
    chk(irq === 1'b1, "write irq");
    tx_irq_enable = 1'b0;
  endtask
  task automatic t_fifo;
    int j;
    port_enable = 1'b0;
    tick(1);
    wr_valid = 1'b1;
    for (int i = 0; i < 8; i++) begin
      wr_data = 8'h50 + i[7:0];
      tick(1);
    end
    wr_valid = 1'b0;
    chk(wr_ready === 1'b0, "fifo refuses when full");
    pt_sel_n = 1'b0;
    port_enable = 1'b1;
    for (int k = 0; k < 8; k++) begin
      j = 0;
      while (shifter_busy !== 1'b1 && j < 100) begin
        tick(1);
        j++;
      end
      while (shifter_busy !== 1'b0 && j < 1000) begin
        tick(1);
        j++;
      end
      chk(j > 0 && j < 1000, "fifo drain step");
    end
    tick(4);
    chk(wr_ready === 1'b1 && pt_rx === 8'h57, "fifo drained");
    pt_sel_n = 1'b1;
    port_enable = 1'b0;
    tick(2);
    port_enable = 1'b1;
  endtask
  task automatic s_bits(input int n, input logic [7:0] d, output logic [7:0] got);
    got = 8'h00;
    for (int i = 0; i < n; i++) begin
      tb_a = d[7-i];
      tick(20);
      tb_sck = 1'b1;
      got = {got[6:0], pb_w};
      tick(20);
      tb_sck = 1'b0;
    end
  endtask
  task automatic t_slave;
    logic [7:0] got;
    master_select = 1'b0;
    clock_mode_select = 1'b0;
    clock_idle_level = 1'b0;
    tick(3);
    chk(data_pin_b_oe === 1'b0 && slave_ready_n_oe === 1'b0, "released");
    ready_set = 1'b1;
    tick(1);
    ready_set = 1'b0;
    slave_select_n = 1'b0;
    tick(3);
    chk(slave_ready_n_oe === 1'b1 && slave_ready_n_out === 1'b0, "ready set");
    s_bits(3, 8'hff, got);
    slave_select_n = 1'b1;
    tick(3);
    put(8'h96);
    slave_select_n = 1'b0;
    tick(3);
    chk(data_pin_b_oe === 1'b1 && shift_clock_oe === 1'b0 && data_pin_a_oe === 1'b0,
      "slave drives");
    s_bits(8, 8'h6d, got);
    tick(4);
    chk(got === 8'h96 && slave_ready_n_out === 1'b1, "slave byte");
    rd(8'h6d, 1'b0);
    echo_enable = 1'b1;
    slave_select_n = 1'b1;
    tick(3);
    slave_select_n = 1'b0;
    tick(3);
    s_bits(8, 8'hc3, got);
    tick(4);
    chk(got === 8'h61, "echo byte");
    rd(8'hc3, 1'b0);
    echo_enable = 1'b0;
    slave_select_n = 1'b1;
    tick(3);
    chk(data_pin_b_oe === 1'b0 && slave_ready_n_oe === 1'b0, "release");
  endtask
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      report_and_stop();
    end
  end
  initial begin
    tick(2);
    rst = 1'b0;
    tick(1);
    chk(rx_buffer_full === 1'b0 && shifter_busy === 1'b0 && overrun_flag === 1'b0, "reset");
    chk(irq === 1'b0 && slave_ready_n_out === 1'b1 && wr_ready === 1'b1, "reset out");
    for (int i = 0; i < 4; i++) begin
      m_xfer(i[0], i[1], 8'ha5 ^ i[7:0], 8'h3c + i[7:0], 16 + 4 * i, 1'b1);
    end
    t_overrun();
    t_fifo();
    t_slave();
    report_and_stop();
  end
endmodule
`default_nettype wire
